//--- rtl/serial_shift_pkg.sv
package serial_shift_pkg;
  // register byte addresses on the bus
  localparam logic [7:0] ADDR_BUFFER  = 8'h10;
  localparam logic [7:0] ADDR_DATA    = 8'h14;
  localparam logic [7:0] ADDR_STATUS  = 8'h18;
  localparam logic [7:0] ADDR_CONTROL = 8'h1c;
  localparam logic [7:0] ADDR_GLOBAL  = 8'h20;
  // status field positions
  localparam int ST_START = 7;
  localparam int ST_OVF   = 6;
  localparam int ST_STOP  = 5;
  localparam int ST_COLL  = 4;
  // control field positions
  localparam int CR_SIE   = 7;
  localparam int CR_OIE   = 6;
  localparam int CR_WM1   = 5;
  localparam int CR_WM0   = 4;
  localparam int CR_CS1   = 3;
  localparam int CR_CS0   = 2;
  localparam int CR_CLK   = 1;
  localparam int CR_TC    = 0;
  // reset values, counter maximum and mode codes
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [3:0] RST_COUNT   = 4'h0;
  localparam logic [3:0] COUNT_MAX   = 4'hf;
  localparam logic [1:0] WM_OFF      = 2'b00;
  localparam logic [1:0] WM_THREE    = 2'b01;
  localparam logic [1:0] CS_TIMER    = 2'b01;
endpackage

//--- rtl/serial_shift_counter.sv
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
// Function
// - external clock source counts both edges of the clock pin
// - timer zero compare clocks the counter and the shift register
// - counter preset to fifteen overflows on one external edge
// - data write wins over a simultaneous shift
// - register shifts left, clocked by pin, compare match or strobe
// - data and clock inputs work in wire mode zero
// - data pin is driven from bit seven via the output latch
// - latch open first half-cycle on external clock, always otherwise
// - open latch passes a new bit seven at once
// - start flag set by start condition or clock-pin edge
// - start interrupt when flag, enable and global enable set
// - start flag clears by writing one, releasing clock hold
// - start interrupt wakes from every sleep mode
// - overflow flag set when counter wraps fifteen to zero
// - overflow interrupt when flag, enable and global enable set
// - overflow flag clears by write one or buffer read
// - overflow interrupt wakes from idle sleep only
// - stop flag set on stop condition, cleared by one, no interrupt
// - collision bit shows bit seven differing from data pin level
// - counter readable, writable, advances per selected clock
// - clock strobe with external source lets toggle strobe clock
// - wire mode selects off, three-wire or two-wire open drain
// - wire mode three holds clock low after overflow
module serial_shift_counter
  import serial_shift_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        timer_zero_match,
  input  wire logic        serial_in_pin,
  input  wire logic        serial_clock_pin,
  input  wire logic        data_dir_out,
  input  wire logic        clock_dir_out,
  input  wire logic        port_data_bit,
  input  wire logic        port_clock_bit,
  input  wire logic        sleep_idle,
  output logic             data_out_pin,
  output logic             data_out_oe,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             scl_out,
  output logic             scl_oe,
  output logic             start_irq,
  output logic             overflow_irq,
  output logic             wake_req
);
  import serial_shift_pkg::*;

  typedef struct packed {
    logic [1:0] din_sync;
    logic [1:0] clk_sync;
    logic       din_q;
    logic       clk_q;
    logic [7:0] shift;
    logic [7:0] buffer;
    logic [3:0] count;
    logic       start_flag;
    logic       ovf_flag;
    logic       stop_flag;
    logic [7:0] ctrl;
    logic       global_ie;
    logic       latch;
    logic       start_hold;
    logic       ovf_hold;
    logic [31:0] rdata;
    logic       ack;
    logic       o_dout;
    logic       o_doe;
    logic       o_sda_oe;
    logic       o_scl_oe;
    logic       o_sirq;
    logic       o_oirq;
    logic       o_wake;
  } state_t;

  state_t cur;
  state_t next_cur;
  logic   rst_q_n;
  logic [1:0] rst_sync;

  // reset release through two stages; kept apart so the struct has one driver
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_q_n = rst_sync[1];

  // combinational helpers
  logic       req;
  logic       wr;
  logic       rd;
  logic [1:0] wm;
  logic [1:0] cs;
  logic       two_wire;
  logic       ext_src;
  logic       pin_edge;
  logic       rise;
  logic       fall;
  logic       tc_write;
  logic       clk_strobe;
  logic       tick;
  logic       start_det;
  logic       stop_det;
  logic       coll;
  logic       data_wr;
  logic       stat_wr;

  always_comb begin
    req      = wb_cyc_i && wb_stb_i && !cur.ack;
    wr       = req && wb_we_i && wb_sel_i[0];
    rd       = req && !wb_we_i;
    wm       = cur.ctrl[CR_WM1:CR_WM0];
    cs       = cur.ctrl[CR_CS1:CR_CS0];
    two_wire = cur.ctrl[CR_WM1];
    ext_src  = cur.ctrl[CR_CS1];
    data_wr  = wr && (wb_adr_i == ADDR_DATA);
    stat_wr  = wr && (wb_adr_i == ADDR_STATUS);
    rise     = cur.clk_sync[1] && !cur.clk_q;
    fall     = !cur.clk_sync[1] && cur.clk_q;
    pin_edge = rise || fall;
    tc_write = wr && (wb_adr_i == ADDR_CONTROL) && wb_dat_i[CR_TC];
    clk_strobe = wr && (wb_adr_i == ADDR_CONTROL) && wb_dat_i[CR_CLK];
    if (ext_src) begin
      tick = cur.ctrl[CR_CLK] ? tc_write : pin_edge;
    end else if (cs == CS_TIMER) begin
      tick = timer_zero_match;
    end else begin
      tick = clk_strobe;
    end
    // sda falling/rising while scl high
    start_det = two_wire && cur.clk_sync[1] && cur.clk_q && cur.din_q && !cur.din_sync[1];
    stop_det  = two_wire && cur.clk_sync[1] && cur.clk_q && !cur.din_q && cur.din_sync[1];
    coll = cur.shift[7] != cur.din_sync[1];
  end

  always_comb begin
    next_cur = cur;
    // inputs sampled regardless of wire mode
    next_cur.din_sync = {cur.din_sync[0], serial_in_pin};
    next_cur.clk_sync = {cur.clk_sync[0], serial_clock_pin};
    next_cur.din_q    = cur.din_sync[1];
    next_cur.clk_q    = cur.clk_sync[1];

    if (data_wr) begin
      next_cur.shift = wb_dat_i[7:0];
    end else if (tick && !(ext_src && !cur.ctrl[CR_CLK] && (cs[0] ? rise : fall))) begin
      next_cur.shift = {cur.shift[6:0], cur.din_sync[1]};
    end

    if (stat_wr && wb_sel_i[0]) begin
      next_cur.count = wb_dat_i[3:0];
    end else if (tick) begin
      next_cur.count = cur.count + 4'h1;
    end

    // clear by write one or buffer read
    if ((stat_wr && wb_dat_i[ST_OVF]) || (rd && wb_adr_i == ADDR_BUFFER)) begin
      next_cur.ovf_flag = 1'b0;
    end
    // wrap sets overflow, set beats clear
    // preset fifteen overflows on one edge
    if (tick && cur.count == COUNT_MAX && !(stat_wr && wb_sel_i[0])) begin
      next_cur.ovf_flag = 1'b1;
      // copy what the register holds after this clock, shifted or not
      next_cur.buffer   = next_cur.shift;
      next_cur.ovf_hold = (wm == 2'b11);
    end
    if (!next_cur.ovf_flag) begin
      next_cur.ovf_hold = 1'b0;
    end

    // write-one clears start flag and hold
    if (stat_wr && wb_dat_i[ST_START]) begin
      next_cur.start_flag = 1'b0;
      next_cur.start_hold = 1'b0;
    end
    if (start_det) begin
      next_cur.start_flag = 1'b1;
      next_cur.start_hold = clock_dir_out;
    end else if (!two_wire && cs[1] && !cur.ctrl[CR_CLK] && pin_edge) begin
      next_cur.start_flag = 1'b1;
    end

    if (stat_wr && wb_dat_i[ST_STOP]) begin
      next_cur.stop_flag = 1'b0;
    end
    if (stop_det) begin
      next_cur.stop_flag = 1'b1;
    end

    // control: toggle strobe does not store; clock strobe stores only with external source
    if (wr && wb_adr_i == ADDR_CONTROL) begin
      next_cur.ctrl = {wb_dat_i[7:2], wb_dat_i[CR_CLK] & wb_dat_i[CR_CS1], 1'b0};
    end
    if (wr && wb_adr_i == ADDR_GLOBAL) begin
      next_cur.global_ie = wb_dat_i[0];
    end

    // latch open first half on external clock
    // open latch follows bit seven at once
    if (!ext_src || (cur.clk_sync[1] == cs[0])) begin
      next_cur.latch = next_cur.shift[7];
    end

    next_cur.o_dout   = cur.latch;
    next_cur.o_doe    = (wm == WM_THREE) && data_dir_out;
    next_cur.o_sda_oe = two_wire && data_dir_out && !(cur.latch && port_data_bit);
    next_cur.o_scl_oe = two_wire && clock_dir_out &&
                        (!port_clock_bit || cur.start_hold || cur.ovf_hold);
    next_cur.o_sirq = cur.start_flag && cur.ctrl[CR_SIE] && cur.global_ie;
    next_cur.o_oirq = cur.ovf_flag && cur.ctrl[CR_OIE] && cur.global_ie;
    // wake from all or idle only
    next_cur.o_wake = (cur.start_flag && cur.ctrl[CR_SIE]) ||
                      (sleep_idle && cur.ovf_flag && cur.ctrl[CR_OIE]);

    // bus answer one cycle after request
    next_cur.ack = req;
    case (wb_adr_i)
      ADDR_BUFFER:  next_cur.rdata = {24'h0, cur.buffer};
      ADDR_DATA:    next_cur.rdata = {24'h0, cur.shift};
      ADDR_STATUS:  next_cur.rdata = {24'h0, cur.start_flag, cur.ovf_flag, cur.stop_flag,
                                      coll, cur.count};
      ADDR_CONTROL: next_cur.rdata = {24'h0, cur.ctrl};
      ADDR_GLOBAL:  next_cur.rdata = {31'h0, cur.global_ie};
      default:      next_cur.rdata = 32'h0;
    endcase
  end

  // main state register
  always_ff @(posedge clk_sys or negedge rst_q_n) begin
    if (!rst_q_n) begin
      cur.din_sync   <= 2'b11;
      cur.clk_sync   <= 2'b00;
      cur.din_q      <= 1'b1;
      cur.clk_q      <= 1'b0;
      cur.shift      <= RST_BYTE;
      cur.buffer     <= RST_BYTE;
      cur.count      <= RST_COUNT;
      cur.start_flag <= 1'b0;
      cur.ovf_flag   <= 1'b0;
      cur.stop_flag  <= 1'b0;
      cur.ctrl       <= RST_BYTE;
      cur.global_ie  <= 1'b0;
      cur.latch      <= 1'b0;
      cur.start_hold <= 1'b0;
      cur.ovf_hold   <= 1'b0;
      cur.rdata      <= 32'h0;
      cur.ack        <= 1'b0;
      cur.o_dout     <= 1'b0;
      cur.o_doe      <= 1'b0;
      cur.o_sda_oe   <= 1'b0;
      cur.o_scl_oe   <= 1'b0;
      cur.o_sirq     <= 1'b0;
      cur.o_oirq     <= 1'b0;
      cur.o_wake     <= 1'b0;
    end else begin
      cur.din_sync   <= next_cur.din_sync;
      cur.clk_sync   <= next_cur.clk_sync;
      cur.din_q      <= next_cur.din_q;
      cur.clk_q      <= next_cur.clk_q;
      cur.shift      <= next_cur.shift;
      cur.buffer     <= next_cur.buffer;
      cur.count      <= next_cur.count;
      cur.start_flag <= next_cur.start_flag;
      cur.ovf_flag   <= next_cur.ovf_flag;
      cur.stop_flag  <= next_cur.stop_flag;
      cur.ctrl       <= next_cur.ctrl;
      cur.global_ie  <= next_cur.global_ie;
      cur.latch      <= next_cur.latch;
      cur.start_hold <= next_cur.start_hold;
      cur.ovf_hold   <= next_cur.ovf_hold;
      cur.rdata      <= next_cur.rdata;
      cur.ack        <= next_cur.ack;
      cur.o_dout     <= next_cur.o_dout;
      cur.o_doe      <= next_cur.o_doe;
      cur.o_sda_oe   <= next_cur.o_sda_oe;
      cur.o_scl_oe   <= next_cur.o_scl_oe;
      cur.o_sirq     <= next_cur.o_sirq;
      cur.o_oirq     <= next_cur.o_oirq;
      cur.o_wake     <= next_cur.o_wake;
    end
  end

  // outputs straight from flops; open drain drives low only
  assign wb_dat_o     = cur.rdata;
  assign wb_ack_o     = cur.ack;
  assign data_out_pin = cur.o_dout;
  assign data_out_oe  = cur.o_doe;
  assign sda_out      = 1'b0;
  assign sda_oe       = cur.o_sda_oe;
  assign scl_out      = 1'b0;
  assign scl_oe       = cur.o_scl_oe;
  assign start_irq    = cur.o_sirq;
  assign overflow_irq = cur.o_oirq;
  assign wake_req     = cur.o_wake;

  AST_OVF_SET: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
    (tick && cur.count == COUNT_MAX && !stat_wr) |=> cur.ovf_flag) else $error("overflow lost");
  AST_WR_WINS: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
    data_wr |=> cur.shift == $past(wb_dat_i[7:0])) else $error("write lost");
  AST_CNT_INC: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
    (tick && !stat_wr) |=> cur.count == $past(cur.count) + 4'h1) else $error("count bad");
  AST_OVF_CLR: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
    (rd && wb_adr_i == ADDR_BUFFER && !tick) |=> !cur.ovf_flag) else $error("ovf not cleared");
  // start flag only cleared by write one
  AST_START_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
    (cur.start_flag && !(stat_wr && wb_dat_i[ST_START])) |=> cur.start_flag) else $error("start dropped");
  AST_SIRQ: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
    (cur.start_flag && cur.ctrl[CR_SIE] && cur.global_ie) |=> start_irq) else $error("no start irq");
  AST_OIRQ: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
    (cur.ovf_flag && cur.ctrl[CR_OIE] && cur.global_ie) |=> overflow_irq) else $error("no ovf irq");
  AST_STOP: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
    stop_det |=> cur.stop_flag) else $error("stop lost");
  // clock held low while overflow pending in mode three
  AST_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
    (cur.ovf_hold && clock_dir_out && wm == 2'b11) |=> scl_oe) else $error("scl not held");
  // no drive in wire mode zero
  AST_OFF: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
    (wm == WM_OFF) |=> !sda_oe && !data_out_oe) else $error("drive in off mode");
endmodule

//--- test/serial_peer.sv
`timescale 1ns/1ps
// far-side serial master: clock stands still low between frames
module serial_peer (
  input  wire logic clk_sys,
  output logic      sclk,
  output logic      sdin
);
  // half of the 160 ns link period, counted in system clocks
  localparam int HALF = 10;
  initial begin
    sclk = 1'b0;
    sdin = 1'b0;
  end
  task automatic wait_half();
    repeat (HALF) @(posedge clk_sys);
  endtask
  // msb first, data set while clock low so the rising edge samples it
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sdin <= b[i];
      wait_half();
      sclk <= 1'b1;
      wait_half();
      sclk <= 1'b0;
    end
    wait_half();
    // released line shows the inverse, so a stale level cannot pass
    sdin <= ~b[0];
  endtask
endmodule

//--- test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import serial_shift_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic        ack, tmatch = 1'b0, ddir = 1'b0, idle = 1'b0, sclk, sdin;
  logic        dout, dout_oe, s_irq, o_irq, wake;
  logic [7:0]  q;
  int          n_fail = 0;
  int          check_count = 0;
  // 125 MHz system clock
  always #4 clk_sys = ~clk_sys;
  serial_peer i_serial_peer (.clk_sys(clk_sys), .sclk(sclk), .sdin(sdin));
  serial_shift_counter i_serial_shift_counter (
    .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .timer_zero_match(tmatch), .serial_in_pin(sdin), .serial_clock_pin(sclk),
    .data_dir_out(ddir), .clock_dir_out(1'b0), .port_data_bit(1'b1),
    .port_clock_bit(1'b1), .sleep_idle(idle), .data_out_pin(dout), .data_out_oe(dout_oe),
    .sda_out(), .sda_oe(), .scl_out(), .scl_oe(), .start_irq(s_irq),
    .overflow_irq(o_irq), .wake_req(wake));
  task automatic close_out();
    if (n_fail == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one classic cycle; holds everything until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hf; wdat <= {24'h0, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) chk("bus ack", 8'h00, 8'h01);
    q = rdat[7:0];
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic t_reset_map();
    wb(1'b0, ADDR_BUFFER, 8'h00);
    chk("buffer reset", q, 8'h00);
    wb(1'b1, 8'h3c, 8'h5a);
    wb(1'b0, 8'h3c, 8'h00);
    chk("unmapped read", q, 8'h00);
  endtask
  task automatic t_strobe();
    wb(1'b1, ADDR_STATUS, 8'he0);
    wb(1'b1, ADDR_DATA, 8'h81);
    wb(1'b1, ADDR_CONTROL, 8'h02);
    wb(1'b0, ADDR_DATA, 8'h00);
    chk("strobe shift", q, 8'h02);
    wb(1'b0, ADDR_STATUS, 8'h00);
    chk("strobe count", q & 8'h0f, 8'h01);
  endtask
  task automatic t_timer();
    idle <= 1'b1;
    wb(1'b1, ADDR_GLOBAL, 8'h01);
    wb(1'b1, ADDR_CONTROL, 8'h44);
    wb(1'b1, ADDR_STATUS, 8'hef);
    @(posedge clk_sys);
    tmatch <= 1'b1;
    @(posedge clk_sys);
    tmatch <= 1'b0;
    settle(2);
    chk("ovf irq", {7'h0, o_irq}, 8'h01);
    chk("idle wake", {7'h0, wake}, 8'h01);
    wb(1'b0, ADDR_STATUS, 8'h00);
    chk("wrap to zero", q & 8'h4f, 8'h40);
    wb(1'b1, ADDR_STATUS, 8'h00);
    wb(1'b0, ADDR_STATUS, 8'h00);
    chk("zero write keeps", q & 8'h40, 8'h40);
    wb(1'b0, ADDR_BUFFER, 8'h00);
    chk("buffer copy", q, 8'h04);
    wb(1'b0, ADDR_STATUS, 8'h00);
    chk("buffer read clears", q & 8'h40, 8'h00);
    settle(1);
    chk("ovf irq drop", {7'h0, o_irq}, 8'h00);
    idle <= 1'b0;
  endtask
  task automatic t_external();
    wb(1'b1, ADDR_CONTROL, 8'h88);
    wb(1'b1, ADDR_STATUS, 8'he0);
    i_serial_peer.send_byte(8'ha5);
    settle(6);
    wb(1'b0, ADDR_DATA, 8'h00);
    chk("ext shift in", q, 8'ha5);
    wb(1'b0, ADDR_STATUS, 8'h00);
    chk("both edges wrap", q & 8'h4f, 8'h40);
    chk("edge start flag", q & 8'h80, 8'h80);
    chk("start irq", {7'h0, s_irq}, 8'h01);
    wb(1'b1, ADDR_STATUS, 8'h80);
    settle(1);
    chk("start clear", {7'h0, s_irq}, 8'h00);
    wb(1'b0, ADDR_BUFFER, 8'h00);
    chk("ext buffer copy", q, 8'ha5);
  endtask
  // toggle strobe clocks the counter once the clock strobe is stored
  task automatic t_toggle();
    wb(1'b1, ADDR_CONTROL, 8'h0a);
    wb(1'b1, ADDR_STATUS, 8'he0);
    wb(1'b1, ADDR_CONTROL, 8'h0b);
    wb(1'b1, ADDR_CONTROL, 8'h0b);
    wb(1'b0, ADDR_STATUS, 8'h00);
    chk("toggle count", q & 8'h0f, 8'h02);
  endtask
  task automatic t_edge_irq();
    wb(1'b1, ADDR_CONTROL, 8'h48);
    wb(1'b1, ADDR_STATUS, 8'hef);
    i_serial_peer.send_byte(8'h01);
    settle(6);
    chk("preset edge irq", {7'h0, o_irq}, 8'h01);
  endtask
  task automatic t_dataout();
    ddir <= 1'b1;
    wb(1'b1, ADDR_CONTROL, 8'h10);
    wb(1'b1, ADDR_DATA, 8'h80);
    settle(2);
    chk("msb to pin", {6'h0, dout_oe, dout}, 8'h03);
    // data pin rests low here, so bit seven high must show a collision
    wb(1'b0, ADDR_STATUS, 8'h00);
    chk("collision", q & 8'h10, 8'h10);
    wb(1'b1, ADDR_DATA, 8'h7f);
    settle(2);
    chk("open latch", {7'h0, dout}, 8'h00);
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset_map();
    t_strobe();
    t_timer();
    t_external();
    t_edge_irq();
    t_toggle();
    t_dataout();
    close_out();
  end
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #200000;
    n_fail++;
    close_out();
  end
endmodule
